// ===== logic/timer_status_pkg.sv
// constants for the timer channel status and interrupt block
// assumes a 32-bit classic Wishbone slave with byte addresses
//
// Behaviour
// - Compare-C register is read/write with a 16-bit value in bits 15:0.
// - The second capture register reads its live content at any time.
// - Status bit 0 sets on counter overflow and clears on a status read.
// - Status bit 1 sets on a double capture load without a read, capture only.
// - Status bits 2 and 3 set on compare A and B matches, waveform only.
// - Status bit 4 sets on a compare-C match in either mode.
// - Status bits 5 and 6 set on capture A and B loads, capture only.
// - Status bit 7 sets on an external trigger until the next status read.
// - Status bit 16 shows live whether the counter clock runs.
// - Status bit 17 mirrors line A, pin level or driven level by mode.
// - Status bit 18 mirrors line B, pin level or driven level by mode.
// - Status, enable, disable and mask share bit positions 0 through 7.
// - Writing one to the enable register sets the matching mask bit.
// - Writing one to the disable register clears the matching mask bit.
// - The mask register reads one for each enabled interrupt source.
package timer_status_pkg;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned CMP_W = 16;
    localparam int unsigned NUM_EVT = 8;
    // register byte offsets
    localparam logic [7:0] OFS_FIRST_CAP = 8'h00;
    localparam logic [7:0] OFS_SECOND_CAP = 8'h04;
    localparam logic [7:0] OFS_PERIOD_CMP = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h10;
    localparam logic [7:0] OFS_IRQ_DISABLE = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
    // status bit positions; events 0 to 7 are shared by enable, disable and mask, 16 to 18 are status only
    localparam int unsigned BIT_OVERFLOW = 0;
    localparam int unsigned BIT_OVERRUN = 1;
    localparam int unsigned BIT_CMP_A = 2;
    localparam int unsigned BIT_CMP_B = 3;
    localparam int unsigned BIT_CMP_C = 4;
    localparam int unsigned BIT_LOAD_A = 5;
    localparam int unsigned BIT_LOAD_B = 6;
    localparam int unsigned BIT_EXT_TRIG = 7;
    localparam int unsigned BIT_CLK_RUN = 16;
    localparam int unsigned BIT_LINE_A = 17;
    localparam int unsigned BIT_LINE_B = 18;
    // flags that exist only in one mode
    localparam logic [7:0] CAPTURE_ONLY = 8'h62;
    localparam logic [7:0] WAVE_ONLY = 8'h0C;
    // reset values
    localparam logic [15:0] RST_PERIOD_CMP = 16'h0000;
    localparam logic [7:0] RST_MASK = 8'h00;
endpackage : timer_status_pkg

// ===== logic/evt_flags_if.sv
// set, clear and state of a bank of sticky event flags
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface evt_flags_if #(parameter int unsigned N = 8);
    logic [N-1:0] set;
    logic [N-1:0] clr;
    logic [N-1:0] flags;
    modport owner (input set, input clr, output flags);
    modport user (output set, output clr, input flags);
endinterface : evt_flags_if

// ===== logic/sticky_flags.sv
// bank of sticky event flags, set wins over clear
// assumes synchronous active-high reset on clk_i
`timescale 1ns/1ps
module sticky_flags #(
    parameter int unsigned N = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    evt_flags_if.owner fl
);
    if (N < 1) begin : g_bad_width
        $error("sticky_flags needs at least one flag");
    end

    // hold each flag until cleared; a same-cycle event keeps it set
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fl.flags <= '0;
        end else begin
            fl.flags <= fl.set | (fl.flags & ~fl.clr);
        end
    end
endmodule : sticky_flags

// ===== logic/pin_sync3.sv
// three-stage synchroniser; output moves once stages two and three agree
// assumes the inputs are asynchronous to clk_i
`timescale 1ns/1ps
module pin_sync3 #(
    parameter int unsigned W = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] level_o
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    if (W < 1) begin : g_bad_width
        $error("pin_sync3 needs at least one bit");
    end

    // shift chain; only s2 reads s1
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= pin_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // accept a bit only when the last two stages agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level_o <= '0;
        end else begin
            for (int i = 0; i < int'(W); i++) begin
                if (s2_reg[i] == s3_reg[i]) begin
                    level_o[i] <= s3_reg[i];
                end
            end
        end
    end
endmodule : pin_sync3

// ===== logic/timer_channel_status_irq.sv
// status, event flags, interrupt mask and compare-C value of a timer channel
// assumes the counter core on clk_i delivers one-cycle event pulses,
// live capture values and the levels it drives on the two i/o lines
//
// Decided for this implementation: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
module timer_channel_status_irq (
    input wire logic clk_i,
    input wire logic rst_i,
    // classic wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // counter core, same clock
    input wire logic wave_mode_i,
    input wire logic clk_running_i,
    input wire logic ovf_evt_i,
    input wire logic cmp_a_evt_i,
    input wire logic cmp_b_evt_i,
    input wire logic cmp_c_evt_i,
    input wire logic load_a_evt_i,
    input wire logic load_b_evt_i,
    input wire logic ext_trig_evt_i,
    input wire logic [15:0] first_capture_i,
    input wire logic [15:0] second_capture_i,
    input wire logic line_a_drive_i,
    input wire logic line_b_drive_i,
    // i/o line pins, asynchronous
    input wire logic io_line_a_i,
    input wire logic io_line_b_i,
    // to the counter core and interrupt controller
    output logic [15:0] period_compare_o,
    output logic irq_o
);
    localparam int unsigned N = timer_status_pkg::NUM_EVT;

    evt_flags_if #(.N(N)) ev ();

    logic req;
    logic commit;
    logic commit_wr;
    logic commit_rd;
    logic [7:0] word_adr;
    logic [7:0] valid_mask;
    logic [7:0] flag_view;
    logic [31:0] stat_view;
    logic [31:0] rd_mux;
    logic [1:0] pin_level;
    logic line_a_mirror;
    logic line_b_mirror;
    logic [7:0] mask_reg;
    logic unread_a_reg;
    logic unread_b_reg;
    logic [7:0] ier_bits;
    logic [7:0] idr_bits;
    logic [7:0] wr_clear;
    logic [7:0] rd_clear;

    // flag bank and pin synchronisers
    sticky_flags #(.N(N)) u_flags (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .fl(ev.owner)
    );

    pin_sync3 #(.W(2)) u_pins (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i({io_line_b_i, io_line_a_i}),
        .level_o(pin_level)
    );

    // bus decode; a request commits on the edge where ack is high
    assign req = cyc_i & stb_i;
    assign commit = req & ack_o;
    assign commit_wr = commit & we_i;
    assign commit_rd = commit & ~we_i;
    assign word_adr = {adr_i[7:2], 2'b00};

    // mirrors follow the pin in capture mode, the drive in waveform mode
    assign line_a_mirror = wave_mode_i ? line_a_drive_i : pin_level[0];
    assign line_b_mirror = wave_mode_i ? line_b_drive_i : pin_level[1];

    // flags that belong to the other mode read as zero
    assign valid_mask = wave_mode_i ? ~timer_status_pkg::CAPTURE_ONLY
                                    : ~timer_status_pkg::WAVE_ONLY;
    assign flag_view = ev.flags & valid_mask;

    // status word: sticky flags low, live state at 16..18
    always_comb begin
        stat_view = '0;
        stat_view[7:0] = flag_view;
        stat_view[timer_status_pkg::BIT_CLK_RUN] = clk_running_i;
        stat_view[timer_status_pkg::BIT_LINE_A] = line_a_mirror;
        stat_view[timer_status_pkg::BIT_LINE_B] = line_b_mirror;
    end

    // event sets, gated by mode
    always_comb begin
        ev.set = '0;
        ev.set[timer_status_pkg::BIT_OVERFLOW] = ovf_evt_i;
        ev.set[timer_status_pkg::BIT_OVERRUN] = ~wave_mode_i &
            ((load_a_evt_i & unread_a_reg) |
             (load_b_evt_i & unread_b_reg));
        ev.set[timer_status_pkg::BIT_CMP_A] = wave_mode_i & cmp_a_evt_i;
        ev.set[timer_status_pkg::BIT_CMP_B] = wave_mode_i & cmp_b_evt_i;
        ev.set[timer_status_pkg::BIT_CMP_C] = cmp_c_evt_i;
        ev.set[timer_status_pkg::BIT_LOAD_A] = ~wave_mode_i & load_a_evt_i;
        ev.set[timer_status_pkg::BIT_LOAD_B] = ~wave_mode_i & load_b_evt_i;
        ev.set[timer_status_pkg::BIT_EXT_TRIG] = ext_trig_evt_i;
    end

    // a status read clears only the bits it reported, so an event that
    // lands between sampling and commit survives; write-one also clears
    assign rd_clear = (commit_rd &&
        word_adr == timer_status_pkg::OFS_STATUS) ? dat_o[7:0] : 8'h00;
    assign wr_clear = (commit_wr && sel_i[0] &&
        word_adr == timer_status_pkg::OFS_STATUS) ? dat_i[7:0] : 8'h00;
    assign ev.clr = rd_clear | wr_clear;

    // enable and disable strobes, byte lane 0 only
    assign ier_bits = (commit_wr && sel_i[0] &&
        word_adr == timer_status_pkg::OFS_IRQ_ENABLE) ? dat_i[7:0] : 8'h00;
    assign idr_bits = (commit_wr && sel_i[0] &&
        word_adr == timer_status_pkg::OFS_IRQ_DISABLE) ? dat_i[7:0] : 8'h00;

    // read multiplexer; unmapped and write-only offsets read zero
    always_comb begin
        rd_mux = '0;
        case (word_adr)
            timer_status_pkg::OFS_FIRST_CAP: begin
                rd_mux[15:0] = first_capture_i;
            end
            timer_status_pkg::OFS_SECOND_CAP: begin
                rd_mux[15:0] = second_capture_i;
            end
            timer_status_pkg::OFS_PERIOD_CMP: begin
                rd_mux[15:0] = period_compare_o;
            end
            timer_status_pkg::OFS_STATUS: begin
                rd_mux = stat_view;
            end
            timer_status_pkg::OFS_IRQ_MASK: begin
                rd_mux[7:0] = mask_reg;
            end
            default: begin
                rd_mux = '0;
            end
        endcase
    end

    // ack one cycle after the request; read data sampled with it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= '0;
        end else begin
            ack_o <= req & ~ack_o;
            if (req && !ack_o) begin
                dat_o <= we_i ? 32'h0000_0000 : rd_mux;
            end
        end
    end

    // compare-c value, byte lanes 0 and 1
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            period_compare_o <= timer_status_pkg::RST_PERIOD_CMP;
        end else if (commit_wr &&
                     word_adr == timer_status_pkg::OFS_PERIOD_CMP) begin
            if (sel_i[0]) begin
                period_compare_o[7:0] <= dat_i[7:0];
            end
            if (sel_i[1]) begin
                period_compare_o[15:8] <= dat_i[15:8];
            end
        end
    end

    // interrupt mask: enable sets, disable clears
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_reg <= timer_status_pkg::RST_MASK;
        end else begin
            mask_reg <= (mask_reg | ier_bits) & ~idr_bits;
        end
    end

    // unread tracking per capture register; a load beats a read
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            unread_a_reg <= 1'b0;
            unread_b_reg <= 1'b0;
        end else begin
            if (load_a_evt_i && !wave_mode_i) begin
                unread_a_reg <= 1'b1;
            end else if (commit_rd &&
                         word_adr == timer_status_pkg::OFS_FIRST_CAP) begin
                unread_a_reg <= 1'b0;
            end
            if (load_b_evt_i && !wave_mode_i) begin
                unread_b_reg <= 1'b1;
            end else if (commit_rd &&
                         word_adr == timer_status_pkg::OFS_SECOND_CAP) begin
                unread_b_reg <= 1'b0;
            end
        end
    end

    // level interrupt from any enabled, visible flag
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(flag_view & mask_reg);
        end
    end

    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    chk_ovf_sets: assert property (
        ovf_evt_i |=> ev.flags[0])
        else $error("overflow flag not set");

    chk_overrun_wave: assert property (
        wave_mode_i |-> !stat_view[1])
        else $error("overrun visible in waveform mode");

    chk_double_load: assert property (
        (!wave_mode_i && load_a_evt_i && unread_a_reg)
        ##1 !wave_mode_i |-> stat_view[1])
        else $error("double load did not flag overrun");

    chk_cmp_capture: assert property (
        !wave_mode_i |-> stat_view[3:2] == 2'b00)
        else $error("compare a or b visible in capture mode");

    chk_cmpc_sets: assert property (
        cmp_c_evt_i |=> stat_view[4])
        else $error("compare c flag not set");

    chk_load_sets: assert property (
        (load_b_evt_i && !wave_mode_i) ##1 !wave_mode_i |-> stat_view[6])
        else $error("load b flag not set");

    chk_read_clears: assert property (
        (commit_rd && word_adr == timer_status_pkg::OFS_STATUS &&
         dat_o[7] && !ext_trig_evt_i) |=> !ev.flags[7])
        else $error("status read left trigger flag set");

    chk_status_data: assert property (
        (req && !ack_o && !we_i &&
         word_adr == timer_status_pkg::OFS_STATUS)
        |=> ack_o && dat_o[16] == $past(clk_running_i))
        else $error("status read lost clock state");

    chk_enable_sets: assert property (
        (ier_bits != 8'h00) && (idr_bits == 8'h00)
        |=> (mask_reg & $past(ier_bits)) == $past(ier_bits))
        else $error("enable write did not set mask");

    chk_disable_clears: assert property (
        idr_bits != 8'h00 |=> (mask_reg & $past(idr_bits)) == 8'h00)
        else $error("disable write did not clear mask");

    chk_irq_level: assert property (
        ##1 irq_o == $past(|(flag_view & mask_reg)))
        else $error("interrupt does not follow flags and mask");

    chk_rc_write: assert property (
        (commit_wr && sel_i[1:0] == 2'b11 &&
         word_adr == timer_status_pkg::OFS_PERIOD_CMP)
        |=> period_compare_o == $past(dat_i[15:0]))
        else $error("compare c write not stored");

    chk_ack_pulse: assert property (
        ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");

    chk_second_cap_read: assert property (
        (req && !ack_o && !we_i &&
         word_adr == timer_status_pkg::OFS_SECOND_CAP)
        |=> dat_o == {16'h0000, $past(second_capture_i)})
        else $error("second capture read not live");

    chk_cmp_a_sets: assert property (
        (cmp_a_evt_i && wave_mode_i) ##1 wave_mode_i
        |-> stat_view[timer_status_pkg::BIT_CMP_A])
        else $error("compare a flag not set");

    chk_cmp_b_sets: assert property (
        (cmp_b_evt_i && wave_mode_i) ##1 wave_mode_i
        |-> stat_view[timer_status_pkg::BIT_CMP_B])
        else $error("compare b flag not set");

    chk_load_a_sets: assert property (
        (load_a_evt_i && !wave_mode_i) ##1 !wave_mode_i
        |-> stat_view[timer_status_pkg::BIT_LOAD_A])
        else $error("load a flag not set");

    chk_trig_sets: assert property (
        ext_trig_evt_i |=> stat_view[timer_status_pkg::BIT_EXT_TRIG])
        else $error("trigger flag not set");

    chk_ovf_read_clear: assert property (
        (commit_rd && word_adr == timer_status_pkg::OFS_STATUS &&
         dat_o[0] && !ovf_evt_i)
        |=> !stat_view[timer_status_pkg::BIT_OVERFLOW])
        else $error("status read left overflow flag set");

    chk_mask_read: assert property (
        (req && !ack_o && !we_i &&
         word_adr == timer_status_pkg::OFS_IRQ_MASK)
        |=> dat_o == {24'h00_0000, $past(mask_reg)})
        else $error("mask read does not show enabled sources");

    chk_mask_stable: assert property (
        (ier_bits == 8'h00 && idr_bits == 8'h00) |=> $stable(mask_reg))
        else $error("mask changed without a set or clear");

    chk_irq_rises: assert property (
        (cmp_c_evt_i && mask_reg[timer_status_pkg::BIT_CMP_C] &&
         idr_bits == 8'h00)
        |-> ##2 irq_o)
        else $error("enabled compare c event raised no interrupt");

    chk_mirror_a_pin: assert property (
        (!wave_mode_i && io_line_a_i) [*5]
        |-> stat_view[timer_status_pkg::BIT_LINE_A])
        else $error("line a mirror missed a steady high pin");

    chk_mirror_b_pin: assert property (
        (!wave_mode_i && !io_line_b_i) [*5]
        |-> !stat_view[timer_status_pkg::BIT_LINE_B])
        else $error("line b mirror missed a steady low pin");

    chk_mask_reset: assert property (
        @(posedge clk_i) disable iff (1'b0)
        rst_i |=> (mask_reg == 8'h00) && !irq_o)
        else $error("reset left mask or interrupt set");

    cov_irq_rise: cover property (!irq_o ##1 irq_o);
    cov_overrun: cover property (ev.set[1]);
    cov_read_clear: cover property (rd_clear != 8'h00);
    cov_set_and_clear: cover property ((ev.set & ev.clr) != 8'h00);
    cov_wave_trig: cover property (wave_mode_i && ext_trig_evt_i);
endmodule : timer_channel_status_irq

// ===== dv/timer_channel_status_irq_tb.sv
// self-checking bench for the timer channel status and interrupt block
// assumes the design files under logic/ are compiled first
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin \
    err_count++; $display("unexpected at %0t: got %h want %h", \
    $time, got, exp); end end
module timer_channel_status_irq_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'hf;
    logic [31:0] dat_i = 32'h0000_0000;
    logic [31:0] dat_o;
    logic ack_o;
    logic wave_mode_i = 1'b0;
    logic clk_running_i = 1'b0;
    logic [7:0] ev = 8'h00;
    logic [15:0] cap_a = 16'h0000;
    logic [15:0] cap_b = 16'h0000;
    logic drv_a = 1'b0;
    logic drv_b = 1'b0;
    logic pin_a = 1'b0;
    logic pin_b = 1'b0;
    logic [15:0] period_compare_o;
    logic irq_o;
    int err_count = 0;
    int tests_run = 0;
    logic [31:0] expq[$];

    // 125 MHz clock
    always #4 clk_i = ~clk_i;

    timer_channel_status_irq DUT (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .wave_mode_i(wave_mode_i),
        .clk_running_i(clk_running_i), .ovf_evt_i(ev[0]),
        .cmp_a_evt_i(ev[2]), .cmp_b_evt_i(ev[3]), .cmp_c_evt_i(ev[4]),
        .load_a_evt_i(ev[5]), .load_b_evt_i(ev[6]),
        .ext_trig_evt_i(ev[7]), .first_capture_i(cap_a),
        .second_capture_i(cap_b), .line_a_drive_i(drv_a),
        .line_b_drive_i(drv_b), .io_line_a_i(pin_a), .io_line_b_i(pin_b),
        .period_compare_o(period_compare_o), .irq_o(irq_o)
    );

    // prints the counts and the verdict, then ends the run
    task automatic test_done();
        if (expq.size() != 0) begin
            err_count++;
            $display("unexpected at %0t: reads left unanswered", $time);
        end
        $display("comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done

    // one classic wishbone cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_count++;
            $display("unexpected at %0t: no bus answer", $time);
        end
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask : wb

    // read that notes its expected data for the monitor
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expq.push_back(e);
        wb(1'b0, a, 32'h0000_0000);
    endtask : rd

    // one-cycle event pulses, then time for the pin synchroniser
    task automatic pulse(input logic [7:0] b);
        @(posedge clk_i);
        ev <= b;
        @(posedge clk_i);
        ev <= 8'h00;
        repeat (5) @(posedge clk_i);
    endtask : pulse

    // live status bits expected from the current inputs
    function automatic logic [31:0] live_bits();
        logic [31:0] v;
        v = 32'h0000_0000;
        v[16] = clk_running_i;
        v[17] = wave_mode_i ? drv_a : pin_a;
        v[18] = wave_mode_i ? drv_b : pin_b;
        return v;
    endfunction : live_bits

    // monitor: every read answer is compared with the oldest note
    always @(posedge clk_i) begin
        logic [31:0] want;
        if (ack_o === 1'b1 && we_i === 1'b0) begin
            if (expq.size() == 0) begin
                err_count++;
                $display("unexpected at %0t: read with no note", $time);
            end else begin
                want = expq.pop_front();
                `CHK(dat_o, want)
            end
        end
    end

    // watchdog against a hung bus or sequence
    initial begin
        #(8 * 8000);
        err_count++;
        $display("unexpected at %0t: run timed out", $time);
        test_done();
    end

    // main sequence
    initial begin
        logic [31:0] r;
        logic [7:0] m;
        logic [7:0] d;
        logic [7:0] ok;
        r = $urandom(32'h0000_ddfb);
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        // reset state of mask, compare value, status and interrupt
        rd(timer_status_pkg::OFS_IRQ_MASK, 32'h0000_0000);
        rd(timer_status_pkg::OFS_PERIOD_CMP, 32'h0000_0000);
        rd(timer_status_pkg::OFS_STATUS, live_bits());
        `CHK(irq_o, 1'b0)
        // compare value keeps only its low 16 bits
        r = $urandom;
        wb(1'b1, timer_status_pkg::OFS_PERIOD_CMP, r);
        rd(timer_status_pkg::OFS_PERIOD_CMP, {16'h0000, r[15:0]});
        `CHK(period_compare_o, r[15:0])
        // capture values read live, twice with new content
        repeat (2) begin
            r = $urandom;
            cap_a <= r[15:0];
            cap_b <= r[31:16];
            @(posedge clk_i);
            rd(timer_status_pkg::OFS_SECOND_CAP, {16'h0000, r[31:16]});
            rd(timer_status_pkg::OFS_FIRST_CAP, {16'h0000, r[15:0]});
        end
        // unmapped and write-only places read zero
        rd(8'h1c, 32'h0000_0000);
        rd(timer_status_pkg::OFS_IRQ_ENABLE, 32'h0000_0000);
        // each event except overrun in each mode, then clear on read
        for (int md = 0; md < 2; md++) begin
            wave_mode_i <= md[0];
            wb(1'b1, timer_status_pkg::OFS_STATUS, 32'h0000_00ff);
            ok = md ? ~timer_status_pkg::CAPTURE_ONLY
                    : ~timer_status_pkg::WAVE_ONLY;
            for (int b = 0; b < 8; b++) begin
                if (b == 1) continue;
                r = $urandom;
                clk_running_i <= r[0];
                pin_a <= r[1];
                pin_b <= r[2];
                drv_a <= r[3];
                drv_b <= r[4];
                pulse(8'h01 << b);
                rd(timer_status_pkg::OFS_STATUS, live_bits() |
                   {24'h0, (8'h01 << b) & ok});
                rd(timer_status_pkg::OFS_STATUS, live_bits());
            end
        end
        // two unread loads of the first capture register
        wave_mode_i <= 1'b0;
        wb(1'b1, timer_status_pkg::OFS_STATUS, 32'h0000_00ff);
        rd(timer_status_pkg::OFS_FIRST_CAP, {16'h0000, cap_a});
        pulse(8'h20);
        pulse(8'h20);
        rd(timer_status_pkg::OFS_STATUS, live_bits() | 32'h0000_0022);
        // mask set and cleared bit by bit, upper bits ignored
        r = $urandom;
        m = r[7:0];
        d = r[15:8];
        wb(1'b1, timer_status_pkg::OFS_IRQ_ENABLE, {r[31:8], m});
        rd(timer_status_pkg::OFS_IRQ_MASK, {24'h0, m});
        wb(1'b1, timer_status_pkg::OFS_IRQ_DISABLE, {24'h0, d});
        rd(timer_status_pkg::OFS_IRQ_MASK, {24'h0, m & ~d});
        wb(1'b1, timer_status_pkg::OFS_IRQ_DISABLE, 32'h0000_00ff);
        rd(timer_status_pkg::OFS_IRQ_MASK, 32'h0000_0000);
        // enabled event raises the interrupt, a status read drops it
        wb(1'b1, timer_status_pkg::OFS_IRQ_ENABLE, 32'h0000_0010);
        pulse(8'h10);
        `CHK(irq_o, 1'b1)
        rd(timer_status_pkg::OFS_STATUS, live_bits() | 32'h0000_0010);
        repeat (2) @(posedge clk_i);
        `CHK(irq_o, 1'b0)
        // masked event sets its flag but no interrupt
        wb(1'b1, timer_status_pkg::OFS_IRQ_DISABLE, 32'h0000_0010);
        pulse(8'h10);
        `CHK(irq_o, 1'b0)
        rd(timer_status_pkg::OFS_STATUS, live_bits() | 32'h0000_0010);
        // mid-run reset clears mask, flags, compare value and interrupt
        wb(1'b1, timer_status_pkg::OFS_IRQ_ENABLE, 32'h0000_00ff);
        pulse(8'h81);
        `CHK(irq_o, 1'b1)
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        `CHK(irq_o, 1'b0)
        rd(timer_status_pkg::OFS_IRQ_MASK, 32'h0000_0000);
        rd(timer_status_pkg::OFS_PERIOD_CMP, 32'h0000_0000);
        rd(timer_status_pkg::OFS_STATUS, live_bits());
        repeat (2) @(posedge clk_i);
        test_done();
    end
endmodule : timer_channel_status_irq_tb
